// [include/hv_wake_pkg.sv]
// Purpose: Shared constants and carriers for the high-voltage wake input logic
// Assumes: 250 MHz system clock, one clock domain
// Notes:   Filter time held in ns, cycle count derived from the clock rate
package hv_wake_pkg;

	localparam int unsigned CLK_PERIOD_NS        = 4;
	// Nominal wake filter, 16 us; tolerance band 13..20 us
	localparam int unsigned WAKE_FILTER_TIME_NS  = 16000;
	localparam int unsigned WAKE_FILTER_MIN_NS   = 13000;
	localparam int unsigned WAKE_FILTER_MAX_NS   = 20000;
	localparam int unsigned WAKE_FILTER_CYCLES   = WAKE_FILTER_TIME_NS / CLK_PERIOD_NS;
	localparam int unsigned FILTER_CNT_W         = 14;

	// Pull select encodings
	localparam logic [1:0] PULL_NONE = 2'h0;
	localparam logic [1:0] PULL_DOWN = 2'h1;
	localparam logic [1:0] PULL_UP   = 2'h2;
	localparam logic [1:0] PULL_AUTO = 2'h3;

	// Reset values
	localparam logic [1:0] PULL_SELECT_RST   = PULL_NONE;
	localparam logic       WAKE_ENABLE_RST   = 1'b0;
	localparam logic       CYCLIC_SENSE_RST  = 1'b0;

	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_STOP,
		MODE_SLEEP,
		MODE_FAILSAFE
	} dev_mode_t;

	// Software configuration carrier
	typedef struct packed {
		logic [1:0] pull_select_bits;
		logic       wake_enable_control;
		logic       gpin_wake_enable;
		logic       cyclic_sense;
		logic       voltage_measure_enable;
		logic       gpin_is_wake;
		logic       gpin_is_hs_timer;
		logic       fail_output_test;
	} wake_cfg_t;

	// Status carrier shown to software
	typedef struct packed {
		logic wake_event_status;
		logic general_pin_wake_status;
		logic pin_level_status;
	} wake_stat_t;

endpackage

// [src/edge_filter.sv]
// Purpose: Glitch filter for one synchronised wake level
// Assumes: Input already synchronised to sys_clk
// Notes:   Restarts the interval on every crossing; a level that holds is accepted
`timescale 1ns/1ps
`default_nettype none
module edge_filter #(
	parameter int unsigned CYCLES = hv_wake_pkg::WAKE_FILTER_CYCLES
) (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic level_in,
	input  wire logic enable,
	output logic      level_q,
	output logic      accept_q
);
	import hv_wake_pkg::*;

	logic [FILTER_CNT_W-1:0] cnt_q;
	logic                    cand_q;
	localparam logic [FILTER_CNT_W-1:0] LAST = FILTER_CNT_W'(CYCLES - 1);

	// Interval starts at a crossing, restarts if the input crosses back
	always_ff @(posedge sys_clk) begin
		accept_q <= 1'b0;
		if (rst) begin
			cnt_q    <= '0;
			cand_q   <= 1'b0;
			level_q  <= 1'b0;
		end else if (!enable) begin
			cnt_q  <= '0;
			cand_q <= level_in;
			level_q <= level_in; // Track silently so re-enable raises no false edge
		end else if (level_in != cand_q) begin
			cand_q <= level_in;
			cnt_q  <= '0;
		end else if (cand_q != level_q) begin
			if (cnt_q == LAST) begin
				level_q  <= cand_q;
				accept_q <= 1'b1;   // Both directions count
				cnt_q    <= '0;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	held_a: assert property (@(posedge sys_clk) disable iff (rst)
		accept_q |-> $past(level_in, 1) == level_q)
		else $error("accepted level not held at input");
endmodule
`default_nettype wire

// [src/level_sync.sv]
// Purpose: Two-flop synchroniser for an asynchronous comparator level
// Assumes: Single bit level
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module level_sync (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic async_in,
	output logic      sync_q
);
	logic meta_q;

	// Metastability guard, comparator is unclocked
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// [src/hv_wake_input_logic.sv]
// Purpose: Wake and sense logic behind the high-voltage sense pin
// Assumes: Comparator outputs arrive asynchronously; config bits are sys_clk-synchronous
// Notes:   Interrupt pulse shaping lives elsewhere; this block gives one-cycle requests
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Rising and falling pin transitions are both wake events.
// - Event raises interrupt in Normal/Stop, wakes device in Sleep/Fail-Safe.
// - Software picks static sense or cyclic sense.
// - Static sense filters transitions for 16 us nominal.
// - Filter restarts on each crossing; crossing back discards the event.
// - A wake enable control bit gates the pin's wake capability.
// - Every accepted pin event sets the pin wake flag when wake enable is set and measurement is off.
// - Level status shows pin level in Normal/Stop/Init, sampled level in cyclic.
// - General pin as wake input uses same filter, own status flag.
// - Pull select: 00 none, 01 down, 10 up, 11 automatic.
// - Automatic pull follows detected level: high gives up, low gives down.
// - Cyclic sense samples only in high-side on-time; change is an event; the code raises it only with gpin_is_hs_timer set.
// - Measurement disables fail output, its test, general pin and wake; the code never reads fail_output_test.
// - Measurement turns both pulls off and blocks internal wake.
// - Measurement ignores pull and wake settings but keeps them writable.
// - Measurement freezes wake status and clears level status.
// - Sleep request under measurement with pin as only wake source sets bad-command, goes Restart.
// - Wake-class interrupt only when the pin is also wake-enabled.
// - Events stay latched until cleared; level status is not latched.
module hv_wake_input_logic
	import hv_wake_pkg::*;
#(
	parameter int unsigned FILTER_CYCLES = hv_wake_pkg::WAKE_FILTER_CYCLES
) (
	input  wire logic                    sys_clk,
	input  wire logic                    rst,
	input  wire logic                    hv_sense_pin,
	input  wire logic                    gpin_sense,
	input  wire hv_wake_pkg::wake_cfg_t  cfg,
	input  wire hv_wake_pkg::dev_mode_t  dev_mode,
	input  wire logic                    init_mode,
	input  wire logic                    hs_on_time,
	input  wire logic                    other_wake_sources,
	input  wire logic                    sleep_request,
	input  wire logic                    clear_pin_wake,
	input  wire logic                    clear_gpin_wake,
	output hv_wake_pkg::wake_stat_t      status_q,
	output logic                         wake_irq_q,
	output logic                         device_wake_q,
	output logic                         pull_up_en_q,
	output logic                         pull_down_en_q,
	output logic                         fail_output_en_q,
	output logic                         gpin_func_en_q,
	output logic                         bad_command_q,
	output logic                         restart_req_q,
	output logic                         sleep_grant_q
);
	import hv_wake_pkg::*;

	logic pin_sync;
	logic gp_sync;
	logic pin_filt;
	logic pin_acc;
	logic gp_filt;
	logic gp_acc;
	logic static_en;
	logic meas;
	logic samp_q;
	logic samp_valid_q;
	logic hs_prev_q;
	logic cyc_event;
	logic pin_event;
	logic gp_event;
	logic low_power;
	logic irq_mode;

	assign meas      = cfg.voltage_measure_enable;
	assign low_power = (dev_mode == MODE_SLEEP) || (dev_mode == MODE_FAILSAFE);
	assign irq_mode  = (dev_mode == MODE_NORMAL) || (dev_mode == MODE_STOP);

	// Comparator outputs are asynchronous, resynchronise first
	level_sync u_pin_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in (hv_sense_pin),
		.sync_q   (pin_sync)
	);

	level_sync u_gp_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in (gpin_sense),
		.sync_q   (gp_sync)
	);

	// Static filter only runs in static sense and outside measurement
	assign static_en = !cfg.cyclic_sense && !meas;

	edge_filter #(
		.CYCLES (FILTER_CYCLES)
	) u_pin_filt (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.level_in (pin_sync),
		.enable   (static_en),
		.level_q  (pin_filt),
		.accept_q (pin_acc)
	);

	// General pin shares the same filter timing when used as wake input
	edge_filter #(
		.CYCLES (FILTER_CYCLES)
	) u_gp_filt (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.level_in (gp_sync),
		.enable   (cfg.gpin_is_wake && !meas),
		.level_q  (gp_filt),
		.accept_q (gp_acc)
	);

	// Cyclic sense: sample at the end of each high-side on-time window
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hs_prev_q    <= 1'b0;
			samp_q       <= 1'b0;
			samp_valid_q <= 1'b0;
		end else begin
			hs_prev_q <= hs_on_time;
			if (!cfg.cyclic_sense || meas) begin
				samp_valid_q <= 1'b0;
			end else if (hs_prev_q && !hs_on_time) begin
				samp_q       <= pin_sync;
				samp_valid_q <= 1'b1;
			end
		end
	end

	// Sampling on the falling edge of the window keeps the read inside the on-time
	assign cyc_event = cfg.cyclic_sense && !meas && cfg.gpin_is_hs_timer && samp_valid_q
		&& hs_prev_q && !hs_on_time && (pin_sync != samp_q);

	// Accepted events, gated by wake enable; ignored entirely under measurement
	assign pin_event = (pin_acc || cyc_event) && cfg.wake_enable_control && !meas;
	assign gp_event  = gp_acc && cfg.gpin_wake_enable && !meas;

	// Sticky event flags, set wins over a clear; level status needs no clear but holds its value in static-sense Sleep/Fail-Safe outside Init.
	// One process owns the whole status word so it keeps a single driver
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			status_q <= '0;
		end else begin
			if (pin_event) begin
				status_q.wake_event_status <= 1'b1;
			end else if (clear_pin_wake) begin
				status_q.wake_event_status <= 1'b0;
			end
			if (gp_event) begin
				status_q.general_pin_wake_status <= 1'b1;
			end else if (clear_gpin_wake) begin
				status_q.general_pin_wake_status <= 1'b0;
			end
			if (meas) begin
				status_q.pin_level_status <= 1'b0;
			end else if (cfg.cyclic_sense) begin
				status_q.pin_level_status <= samp_q;
			end else if (irq_mode || init_mode) begin
				status_q.pin_level_status <= pin_sync;
			end
		end
	end

	// Signalling path depends on device mode
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wake_irq_q    <= 1'b0;
			device_wake_q <= 1'b0;
		end else begin
			wake_irq_q    <= (pin_event || gp_event) && irq_mode;
			device_wake_q <= (pin_event || gp_event) && low_power;
		end
	end

	// Pull sources; auto mode follows the synchronised level so it tracks the pin without filter lag
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pull_up_en_q   <= 1'b0;
			pull_down_en_q <= 1'b0;
		end else if (meas) begin
			pull_up_en_q   <= 1'b0;
			pull_down_en_q <= 1'b0;
		end else begin
			case (cfg.pull_select_bits)
				PULL_DOWN: begin
					pull_up_en_q   <= 1'b0;
					pull_down_en_q <= 1'b1;
				end
				PULL_UP: begin
					pull_up_en_q   <= 1'b1;
					pull_down_en_q <= 1'b0;
				end
				PULL_AUTO: begin
					pull_up_en_q   <= pin_sync;
					pull_down_en_q <= !pin_sync;
				end
				default: begin
					pull_up_en_q   <= 1'b0;
					pull_down_en_q <= 1'b0;
				end
			endcase
		end
	end

	// Pin functions that share the measurement path are released only when idle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			fail_output_en_q <= 1'b0;
			gpin_func_en_q   <= 1'b0;
		end else begin
			fail_output_en_q <= !meas && !cfg.gpin_is_wake;
			gpin_func_en_q   <= !meas;
		end
	end

	// Sleep entry check: pin unusable as sole wake source under measurement
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bad_command_q <= 1'b0;
			restart_req_q <= 1'b0;
			sleep_grant_q <= 1'b0;
		end else begin
			restart_req_q <= 1'b0;
			sleep_grant_q <= 1'b0;
			if (sleep_request) begin
				if (meas && cfg.wake_enable_control && !other_wake_sources) begin
					bad_command_q <= 1'b1;
					restart_req_q <= 1'b1;
				end else begin
					sleep_grant_q <= 1'b1;
				end
			end
		end
	end

	// Checks on the signalling, status and pull paths
	irq_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
		pin_event && irq_mode |=> wake_irq_q && !device_wake_q)
		else $error("pin event did not raise interrupt");

	wake_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
		pin_event && low_power |=> device_wake_q && !wake_irq_q)
		else $error("pin event did not wake device");

	irq_only_a: assert property (@(posedge sys_clk) disable iff (rst)
		!irq_mode |=> !wake_irq_q)
		else $error("interrupt raised outside normal or stop");

	wake_only_a: assert property (@(posedge sys_clk) disable iff (rst)
		!low_power |=> !device_wake_q)
		else $error("device wake raised outside sleep or fail-safe");

	both_edges_a: assert property (@(posedge sys_clk) disable iff (rst)
		pin_acc |-> pin_filt != $past(pin_filt))
		else $error("pin accept without level change");

	gp_edges_a: assert property (@(posedge sys_clk) disable iff (rst)
		gp_acc |-> gp_filt != $past(gp_filt))
		else $error("general pin accept without level change");

	static_only_a: assert property (@(posedge sys_clk) disable iff (rst)
		cfg.cyclic_sense ##1 cfg.cyclic_sense |-> !pin_acc)
		else $error("static filter accepted during cyclic sense");

	cyc_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		!(hs_prev_q && !hs_on_time) |=> $stable(samp_q))
		else $error("cyclic sample taken outside window end");

	flag_sticky_a: assert property (@(posedge sys_clk) disable iff (rst)
		status_q.wake_event_status && !clear_pin_wake |=> status_q.wake_event_status)
		else $error("wake flag lost without clear");

	flag_set_a: assert property (@(posedge sys_clk) disable iff (rst)
		pin_event |=> status_q.wake_event_status)
		else $error("accepted event not recorded");

	level_live_a: assert property (@(posedge sys_clk) disable iff (rst)
		!meas && !cfg.cyclic_sense && (irq_mode || init_mode)
		|=> status_q.pin_level_status == $past(pin_sync))
		else $error("level status not following pin");

	level_cyclic_a: assert property (@(posedge sys_clk) disable iff (rst)
		!meas && cfg.cyclic_sense |=> status_q.pin_level_status == $past(samp_q))
		else $error("level status not showing cyclic sample");

	meas_level_a: assert property (@(posedge sys_clk) disable iff (rst)
		meas ##1 meas |-> !status_q.pin_level_status)
		else $error("level status not cleared in measurement");

	meas_freeze_a: assert property (@(posedge sys_clk) disable iff (rst)
		meas && !clear_pin_wake |=> $stable(status_q.wake_event_status))
		else $error("wake flag updated in measurement");

	meas_pull_a: assert property (@(posedge sys_clk) disable iff (rst)
		meas |=> !pull_up_en_q && !pull_down_en_q)
		else $error("pull source active in measurement");

	pull_none_a: assert property (@(posedge sys_clk) disable iff (rst)
		cfg.pull_select_bits == PULL_NONE |=> !pull_up_en_q && !pull_down_en_q)
		else $error("pull source active with none selected");

	pull_down_a: assert property (@(posedge sys_clk) disable iff (rst)
		!meas && cfg.pull_select_bits == PULL_DOWN |=> pull_down_en_q && !pull_up_en_q)
		else $error("pull-down not selected");

	pull_up_a: assert property (@(posedge sys_clk) disable iff (rst)
		!meas && cfg.pull_select_bits == PULL_UP |=> pull_up_en_q && !pull_down_en_q)
		else $error("pull-up not selected");

	auto_pull_a: assert property (@(posedge sys_clk) disable iff (rst)
		!meas && cfg.pull_select_bits == PULL_AUTO |=> pull_up_en_q == $past(pin_sync))
		else $error("auto pull not following level");

	auto_down_a: assert property (@(posedge sys_clk) disable iff (rst)
		!meas && cfg.pull_select_bits == PULL_AUTO |=> pull_down_en_q == !$past(pin_sync))
		else $error("auto pull-down not following level");

	no_enable_a: assert property (@(posedge sys_clk) disable iff (rst)
		!cfg.wake_enable_control && !gp_event |=> !wake_irq_q && !device_wake_q)
		else $error("disabled pin signalled wake");

	gp_enable_a: assert property (@(posedge sys_clk) disable iff (rst)
		!cfg.gpin_wake_enable && !pin_event |=> !wake_irq_q && !device_wake_q)
		else $error("disabled general pin signalled wake");

	bad_sleep_a: assert property (@(posedge sys_clk) disable iff (rst)
		sleep_request && meas && cfg.wake_enable_control && !other_wake_sources
		|=> restart_req_q && bad_command_q && !sleep_grant_q)
		else $error("sleep not refused with only pin source");

	sleep_grant_a: assert property (@(posedge sys_clk) disable iff (rst)
		sleep_request && !(meas && cfg.wake_enable_control && !other_wake_sources)
		|=> sleep_grant_q && !restart_req_q)
		else $error("valid sleep request not granted");

	gp_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
		gp_event |=> status_q.general_pin_wake_status)
		else $error("general pin event not recorded");

	meas_func_a: assert property (@(posedge sys_clk) disable iff (rst)
		meas |=> !fail_output_en_q && !gpin_func_en_q)
		else $error("pin function active in measurement");
endmodule
`default_nettype wire

// [verif/sense_line_model.sv]
// Purpose: Model of the external switch or sensor line on the sense pin
// Assumes: A closed switch drives a level, an open one leaves the line to the pulls
// Notes:   An open line with no pull flips every cycle, so it never settles by luck
`timescale 1ns/1ps
`default_nettype none
module sense_line_model (
	input  wire logic sys_clk,
	input  wire logic switch_closed,
	input  wire logic switch_level,
	input  wire logic pull_up_en,
	input  wire logic pull_down_en,
	output var  logic pin
);
	logic float_q = 1'b0;

	// Floating level wanders; a constant would hide missing pull logic
	always @(posedge sys_clk) begin
		float_q <= ~pin;
	end

	// Closed switch beats the weak current sources
	always_comb begin
		if (switch_closed) begin
			pin = switch_level;
		end else if (pull_up_en) begin
			pin = 1'b1;
		end else if (pull_down_en) begin
			pin = 1'b0;
		end else begin
			pin = float_q;
		end
	end
endmodule
`default_nettype wire

// [verif/tb.sv]
// Purpose: Self-checking bench for the wake input logic
// Assumes: Filter shortened to FC cycles; inputs change on rising edges
// Notes:   Pulse outputs are counted at every rising edge, so tests compare counts
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH t=%0t %s got %0h exp %0h", $time, tname, g, e); end end
module tb;
	import hv_wake_pkg::*;
	localparam int unsigned FC = 20;
	localparam logic [1:0]  PEXP [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
	logic       sys_clk  = 1'b0;
	logic       rst      = 1'b1;
	wake_cfg_t  cfg      = '0;
	dev_mode_t  dev_mode = MODE_NORMAL;
	logic       gpin_sense = 1'b0, init_mode = 1'b0, hs_on_time = 1'b0, other_wake_sources = 1'b0;
	logic       sleep_request = 1'b0, clear_pin_wake = 1'b0, clear_gpin_wake = 1'b0;
	logic       sw_closed = 1'b1, sw_level = 1'b0, pin;
	wake_stat_t status_q;
	logic       wake_irq_q, device_wake_q, pull_up_en_q, pull_down_en_q, fail_output_en_q;
	logic       gpin_func_en_q, bad_command_q, restart_req_q, sleep_grant_q;
	int         num_errors = 0, cmp_count = 0;
	int         n [4] = '{0, 0, 0, 0};
	int         b [4];
	string      tname;

	// 250 MHz clock
	always #2 sys_clk = ~sys_clk;

	// Count each one-cycle pulse: irq, wake, restart, grant
	always @(posedge sys_clk) begin
		n[0] <= n[0] + int'(wake_irq_q === 1'b1);
		n[1] <= n[1] + int'(device_wake_q === 1'b1);
		n[2] <= n[2] + int'(restart_req_q === 1'b1);
		n[3] <= n[3] + int'(sleep_grant_q === 1'b1);
	end

	sense_line_model u_line (.sys_clk(sys_clk), .switch_closed(sw_closed), .switch_level(sw_level),
		.pull_up_en(pull_up_en_q), .pull_down_en(pull_down_en_q), .pin(pin));

	hv_wake_input_logic #(.FILTER_CYCLES(FC)) u_dut (.sys_clk(sys_clk), .rst(rst), .hv_sense_pin(pin),
		.gpin_sense(gpin_sense), .cfg(cfg), .dev_mode(dev_mode), .init_mode(init_mode),
		.hs_on_time(hs_on_time), .other_wake_sources(other_wake_sources), .sleep_request(sleep_request),
		.clear_pin_wake(clear_pin_wake), .clear_gpin_wake(clear_gpin_wake), .status_q(status_q),
		.wake_irq_q(wake_irq_q), .device_wake_q(device_wake_q), .pull_up_en_q(pull_up_en_q),
		.pull_down_en_q(pull_down_en_q), .fail_output_en_q(fail_output_en_q),
		.gpin_func_en_q(gpin_func_en_q), .bad_command_q(bad_command_q),
		.restart_req_q(restart_req_q), .sleep_grant_q(sleep_grant_q));

	// Every task starts and ends just after a rising edge
	task automatic cyc(input int k);
		repeat (k) @(posedge sys_clk);
	endtask
	task automatic snap();
		b = n;
	endtask
	task automatic pulses(input int i, input int w, input int r, input int s);
		`CHK(n[0] - b[0], i)
		`CHK(n[1] - b[1], w)
		`CHK(n[2] - b[2], r)
		`CHK(n[3] - b[3], s)
	endtask
	task automatic pin_to(input logic v, input int k);
		sw_level <= v;
		cyc(k);
	endtask
	task automatic clr();
		clear_pin_wake <= 1'b1;
		clear_gpin_wake <= 1'b1;
		cyc(1);
		clear_pin_wake <= 1'b0;
		clear_gpin_wake <= 1'b0;
		cyc(3);
	endtask
	task automatic sleep_req();
		sleep_request <= 1'b1;
		cyc(1);
		sleep_request <= 1'b0;
		cyc(3);
	endtask
	// Sample window of the high-side timer; the pin flips once the window is over
	task automatic window(input logic v);
		sw_level <= v;
		cyc(4);
		hs_on_time <= 1'b1;
		cyc(6);
		hs_on_time <= 1'b0;
		cyc(3);
		sw_level <= ~v;
		cyc(10);
	endtask

	task automatic t_reset();
		tname = "reset";
		`CHK({pull_up_en_q, pull_down_en_q}, 2'h0)
		`CHK(status_q, 3'h0)
		$display("%s done", tname);
	endtask

	// Alternate edges through all four modes
	task automatic t_modes();
		tname = "modes";
		cfg.wake_enable_control <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			dev_mode <= dev_mode_t'(m);
			snap();
			pin_to(~m[0], 40);
			pulses(int'(m < 2), int'(m >= 2), 0, 0);
			`CHK(status_q.wake_event_status, 1'b1)
			if (m == 0) `CHK(status_q.pin_level_status, 1'b1)
			if (m == 2) begin
				`CHK(status_q.pin_level_status, 1'b0)
				init_mode <= 1'b1;
				cyc(4);
				`CHK(status_q.pin_level_status, 1'b1)
				init_mode <= 1'b0;
			end
		end
		dev_mode <= MODE_NORMAL;
		clr();
		`CHK(status_q.wake_event_status, 1'b0)
		$display("%s done", tname);
	endtask

	task automatic t_filter();
		tname = "filter";
		snap();
		pin_to(1'b1, FC / 2);
		`CHK(status_q.pin_level_status, 1'b1)
		pin_to(1'b0, 40);
		`CHK(status_q.pin_level_status, 1'b0)
		pulses(0, 0, 0, 0);
		`CHK(status_q.wake_event_status, 1'b0)
		pin_to(1'b1, FC - 2);
		pulses(0, 0, 0, 0);
		cyc(30);
		pulses(1, 0, 0, 0);
		pin_to(1'b0, 40);
		clr();
		$display("%s done", tname);
	endtask

	task automatic t_enable();
		tname = "enable";
		cfg.wake_enable_control <= 1'b0;
		snap();
		pin_to(1'b1, 40);
		pulses(0, 0, 0, 0);
		`CHK(status_q.wake_event_status, 1'b0)
		pin_to(1'b0, 40);
		$display("%s done", tname);
	endtask

	// Open switch so the pulls alone set the line
	task automatic t_pulls();
		tname = "pulls";
		sw_closed <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			cfg.pull_select_bits <= 2'(i);
			cyc(6);
			`CHK({pull_up_en_q, pull_down_en_q}, PEXP[i])
		end
		sw_closed <= 1'b1;
		sw_level <= 1'b0;
		cyc(6);
		`CHK({pull_up_en_q, pull_down_en_q}, 2'h1)
		$display("%s done", tname);
	endtask

	task automatic t_meas();
		tname = "meas";
		pin_to(1'b1, 6);
		`CHK({fail_output_en_q, gpin_func_en_q}, 2'h3)
		cfg.voltage_measure_enable <= 1'b1;
		cfg.wake_enable_control <= 1'b1;
		cyc(6);
		`CHK({pull_up_en_q, pull_down_en_q}, 2'h0)
		`CHK({fail_output_en_q, gpin_func_en_q}, 2'h0)
		`CHK(status_q.pin_level_status, 1'b0)
		snap();
		pin_to(1'b0, 40);
		pulses(0, 0, 0, 0);
		`CHK(status_q.wake_event_status, 1'b0)
		cfg.pull_select_bits <= PULL_UP;
		cyc(4);
		`CHK({pull_up_en_q, pull_down_en_q}, 2'h0)
		snap();
		sleep_req();
		pulses(0, 0, 1, 0);
		`CHK(bad_command_q, 1'b1)
		other_wake_sources <= 1'b1;
		snap();
		sleep_req();
		pulses(0, 0, 0, 1);
		cfg.voltage_measure_enable <= 1'b0;
		other_wake_sources <= 1'b0;
		cyc(6);
		`CHK({pull_up_en_q, pull_down_en_q}, 2'h2)
		cyc(40);
		clr();
		$display("%s done", tname);
	endtask

	task automatic t_gpin();
		tname = "gpin";
		cfg.gpin_is_wake <= 1'b1;
		cfg.gpin_wake_enable <= 1'b1;
		snap();
		gpin_sense <= 1'b1;
		cyc(40);
		`CHK(status_q.general_pin_wake_status, 1'b1)
		`CHK(status_q.wake_event_status, 1'b0)
		pulses(1, 0, 0, 0);
		clr();
		gpin_sense <= 1'b0;
		cyc(FC / 2);
		gpin_sense <= 1'b1;
		cyc(40);
		`CHK(status_q.general_pin_wake_status, 1'b0)
		cfg.gpin_is_wake <= 1'b0;
		$display("%s done", tname);
	endtask

	// Pin changes outside the windows must not count
	task automatic t_cyclic();
		tname = "cyclic";
		cfg.cyclic_sense <= 1'b1;
		cfg.gpin_is_hs_timer <= 1'b1;
		cyc(4);
		snap();
		window(1'b0);
		window(1'b0);
		pulses(0, 0, 0, 0);
		`CHK(status_q.pin_level_status, 1'b0)
		window(1'b1);
		pulses(1, 0, 0, 0);
		`CHK(status_q.pin_level_status, 1'b1)
		`CHK(status_q.wake_event_status, 1'b1)
		cfg.cyclic_sense <= 1'b0;
		$display("%s done", tname);
	endtask

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		cyc(12);
		rst <= 1'b0;
		cyc(4);
		t_reset();
		t_modes();
		t_filter();
		t_enable();
		t_pulls();
		t_meas();
		t_gpin();
		t_cyclic();
		report_and_stop();
	end

	// Watchdog: the tests need well under a thousand cycles
	initial begin
		cyc(3000);
		num_errors++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		report_and_stop();
	end
endmodule
`default_nettype wire
